// ### design/cofg_params.svh
`ifndef COFG_PARAMS_SVH
`define COFG_PARAMS_SVH

// Register byte offsets.
`define COFG_OFF_CTRL 8'h00
`define COFG_OFF_STATUS 8'h04
`define COFG_OFF_IRQ_STS 8'h08
`define COFG_OFF_IRQ_MASK 8'h0C
`define COFG_OFF_EVT_MASK 8'h10
`define COFG_OFF_TSTAMP 8'h14
`define COFG_OFF_EVT_INFO 8'h18
`define COFG_OFF_EVT_TIME 8'h1C
`define COFG_OFF_LOG_SEL 8'h20
`define COFG_OFF_LOG_TIME 8'h24
`define COFG_OFF_LOG_INFO 8'h28
`define COFG_OFF_LOG_REMAIN 8'h2C
`define COFG_OFF_LOG_ELAPSED 8'h30
`define COFG_OFF_LOG_COUNT 8'h34
`define COFG_OFF_REL_BASE 8'h40
`define COFG_OFF_REL_END 8'h60

// Control register field positions.
`define COFG_CTRL_FORCE_LSB 0
`define COFG_CTRL_FEN_BIT 2
`define COFG_CTRL_SG_LSB 4

// Reset values and limits, interval values in milliseconds.
`define COFG_REL_RST_MS 21'h003E8
`define COFG_REL_MAX_MS 21'h1B7740
`define COFG_EVT_MASK_RST 8'hFF

// Timing: one interval tick is one millisecond.
`define COFG_TICK_NS 1000000
`define COFG_CLK_NS 5

`endif

// ### design/cofg_pkg.sv
package cofg_pkg;
    localparam int COFG_NUM_SG = 8;
    localparam int COFG_LOG_DEPTH = 12;
    localparam int COFG_MS_W = 21;

    typedef enum logic [3:0] {
        ST_NORMAL = 4'h1,
        ST_INIT = 4'h2,
        ST_ACTIVE = 4'h4,
        ST_TRIP = 4'h8
    } cofg_fsm_t;

    typedef enum logic [2:0] {
        COND_NORMAL = 3'h0,
        COND_INIT = 3'h1,
        COND_ACTIVE = 3'h2,
        COND_TRIP = 3'h3,
        COND_BLOCKED = 3'h4
    } cofg_cond_t;

    typedef enum logic [1:0] {
        FORCE_NONE = 2'h0,
        FORCE_BLOCKED = 2'h1,
        FORCE_ACTIVE = 2'h2,
        FORCE_TRIP = 2'h3
    } cofg_force_t;

    // Event id is twice the indication index, plus one for the OFF event.
    typedef enum logic [2:0] {
        EVT_INIT_ON = 3'h0,
        EVT_INIT_OFF = 3'h1,
        EVT_BLOCK_ON = 3'h2,
        EVT_BLOCK_OFF = 3'h3,
        EVT_ACTIVE_ON = 3'h4,
        EVT_ACTIVE_OFF = 3'h5,
        EVT_TRIP_ON = 3'h6,
        EVT_TRIP_OFF = 3'h7
    } cofg_evt_t;

    typedef struct packed {
        logic [31:0] stamp;
        cofg_evt_t id;
        logic [2:0] sg;
        logic [COFG_MS_W-1:0] remain;
        logic [COFG_MS_W-1:0] elapsed;
    } cofg_rec_t;

    // Flags order: trip, active, blocked, init.
    typedef struct packed {
        logic [3:0] flags;
        cofg_cond_t cond;
    } cofg_ind_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } cofg_ap_t;

    typedef struct packed {
        cofg_fsm_t fsm;
        logic arm_prev;
        logic [COFG_MS_W-1:0] remain;
        logic [COFG_MS_W-1:0] elapsed;
        cofg_ind_t ind;
        logic [3:0] prev_flags;
        cofg_force_t force_sel;
        logic force_en;
        logic [2:0] sg;
        logic [COFG_NUM_SG-1:0][COFG_MS_W-1:0] rel;
        logic [7:0] irq_sts;
        logic [7:0] irq_mask;
        logic [7:0] evt_mask;
        logic irq;
        logic [31:0] stamp;
        logic evt_stb;
        cofg_rec_t last_evt;
        logic [COFG_LOG_DEPTH-1:0][$bits(cofg_rec_t)-1:0] log;
        logic [3:0] log_wr;
        logic [3:0] log_cnt;
        logic [3:0] log_sel;
        cofg_ap_t ap;
        logic hready;
        logic [31:0] hrdata;
    } cofg_core_t;
endpackage

// ### design/cofg_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cofg_sync
    import cofg_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk, // System clock.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic [W-1:0] d, // Asynchronous inputs.
    output logic [W-1:0] q // Inputs after two flip-flops.
);
    logic [1:0][W-1:0] stg_r;
    logic [1:0][W-1:0] stg_nxt;

    always_comb begin
        stg_nxt[0] = d;
        stg_nxt[1] = stg_r[0];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stg_r <= '0;
        end else begin
            stg_r <= stg_nxt;
        end
    end

    assign q = stg_r[1];
endmodule
`default_nettype wire

// ### design/cofg_tick.sv
`timescale 1ns/1ps
`default_nettype none
module cofg_tick
    import cofg_pkg::*;
#(
    parameter int CYCLES = 200000
) (
    input wire logic clk, // System clock.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic clr, // Restarts the period.
    output logic tick // One-cycle pulse per period.
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } cofg_tick_st_t;

    cofg_tick_st_t st_r;
    cofg_tick_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (clr) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == CW'(CYCLES - 1)) begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule
`default_nettype wire

// ### design/cofg_top.sv
// Function
// - Arm rising edge starts the guard window.
// - Window lasts the release interval, default 1 s.
// - Fault start during window trips at once.
// - Any one fault start input trips.
// - Block input stops the window starting.
// - Blocked, active and trip outputs.
// - Force status overrides outputs when forcing enabled.
// - Condition code: normal, init, active, trip, blocked.
// - ON and OFF events, maskable for storage.
// - Events carry time stamp and process data.
// - Twelve-entry circular log on activation ON.
// - Entry holds time, event, group, remaining, elapsed.
// - Interval comes from active setting group.
`timescale 1ns/1ps
`default_nettype none
`include "cofg_params.svh"
module cofg_top
    import cofg_pkg::*;
#(
    parameter int TICK_CYCLES = `COFG_TICK_NS / `COFG_CLK_NS,
    parameter int NUM_FAULT = 4
) (
    input wire logic clk, // System clock, 200 MHz.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic hsel, // AHB-Lite select.
    input wire logic [31:0] haddr, // AHB-Lite address.
    input wire logic [1:0] htrans, // AHB-Lite transfer type.
    input wire logic hwrite, // AHB-Lite write.
    input wire logic [2:0] hsize, // AHB-Lite size, word only.
    input wire logic [31:0] hwdata, // AHB-Lite write data.
    input wire logic hready, // AHB-Lite bus ready.
    output logic hreadyout, // AHB-Lite slave ready.
    output logic [31:0] hrdata, // AHB-Lite read data.
    output logic hresp, // AHB-Lite response, always OKAY.
    input wire logic arm, // Arm input, rising edge starts window.
    input wire logic block, // Block input.
    input wire logic [NUM_FAULT-1:0] fault_start, // Fault start inputs.
    output logic blocked, // Blocked indication.
    output logic active, // Guard window active indication.
    output logic trip, // Trip indication.
    output logic [2:0] cond_code, // Condition code.
    output logic irq, // Level interrupt.
    output logic evt_stb, // Stored event pulse.
    output logic [2:0] evt_id // Stored event id.
);
    cofg_core_t st_r;
    cofg_core_t st_nxt;
    logic [NUM_FAULT+1:0] sync_q;
    logic arm_s;
    logic block_s;
    logic fault_any;
    logic arm_edge;
    logic start;
    logic win;
    logic tick_win;
    logic tick_free;
    logic [COFG_MS_W-1:0] rel_cur;
    logic [3:0] cur_flags;
    logic [7:0] ev;
    logic [7:0] ev_store;
    logic [4:0] sel_tmp;
    logic [3:0] sel_phys;
    cofg_rec_t sel_rec;
    cofg_rec_t rec;
    logic [31:0] rd_val;
    logic [COFG_MS_W-1:0] wval;

    cofg_sync #(.W(NUM_FAULT + 2)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d({arm, block, fault_start}),
        .q(sync_q)
    );

    assign arm_s = sync_q[NUM_FAULT+1];
    assign block_s = sync_q[NUM_FAULT];
    assign fault_any = |sync_q[NUM_FAULT-1:0];
    assign arm_edge = arm_s & ~st_r.arm_prev;
    assign start = arm_edge & ~block_s & (st_r.fsm != ST_INIT);
    assign win = (st_r.fsm == ST_ACTIVE) || (st_r.fsm == ST_TRIP);
    assign rel_cur = st_r.rel[st_r.sg];

    // The window timer restarts its millisecond phase on each start, so the interval is exact.
    // Millisecond tick.
    cofg_tick #(.CYCLES(TICK_CYCLES)) u_tick_win (
        .clk(clk),
        .sys_rst(sys_rst),
        .clr(start),
        .tick(tick_win)
    );

    cofg_tick #(.CYCLES(TICK_CYCLES)) u_tick_free (
        .clk(clk),
        .sys_rst(sys_rst),
        .clr(1'b0),
        .tick(tick_free)
    );

    always_comb begin
        sel_tmp = {1'b0, st_r.log_wr} + 5'(COFG_LOG_DEPTH) - 5'h01 - {1'b0, st_r.log_sel};
        if (sel_tmp >= 5'(COFG_LOG_DEPTH)) begin
            sel_tmp = sel_tmp - 5'(COFG_LOG_DEPTH);
        end
        sel_phys = sel_tmp[3:0];
        sel_rec = st_r.log[sel_phys];
        rd_val = 32'h00000000;
        case (st_r.ap.addr)
            `COFG_OFF_CTRL: rd_val = {25'h0, st_r.sg, 1'b0, st_r.force_en, st_r.force_sel};
            `COFG_OFF_STATUS: rd_val = {26'h0, st_r.ind.flags[3:1], st_r.ind.cond};
            `COFG_OFF_IRQ_STS: rd_val = {24'h0, st_r.irq_sts};
            `COFG_OFF_IRQ_MASK: rd_val = {24'h0, st_r.irq_mask};
            `COFG_OFF_EVT_MASK: rd_val = {24'h0, st_r.evt_mask};
            `COFG_OFF_TSTAMP: rd_val = st_r.stamp;
            `COFG_OFF_EVT_INFO: rd_val = {1'b0, st_r.last_evt.remain, 1'b0, st_r.last_evt.sg,
                                          3'h0, st_r.last_evt.id};
            `COFG_OFF_EVT_TIME: rd_val = st_r.last_evt.stamp;
            `COFG_OFF_LOG_SEL: rd_val = {28'h0, st_r.log_sel};
            `COFG_OFF_LOG_TIME: rd_val = sel_rec.stamp;
            `COFG_OFF_LOG_INFO: rd_val = {25'h0, sel_rec.sg, 1'b0, sel_rec.id};
            `COFG_OFF_LOG_REMAIN: rd_val = {11'h0, sel_rec.remain};
            `COFG_OFF_LOG_ELAPSED: rd_val = {11'h0, sel_rec.elapsed};
            `COFG_OFF_LOG_COUNT: rd_val = {28'h0, st_r.log_cnt};
            default: begin
                if (st_r.ap.addr >= `COFG_OFF_REL_BASE && st_r.ap.addr < `COFG_OFF_REL_END) begin
                    rd_val = {11'h0, st_r.rel[st_r.ap.addr[4:2]]};
                end
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.arm_prev = arm_s;
        st_nxt.evt_stb = 1'b0;
        wval = (hwdata[COFG_MS_W-1:0] > `COFG_REL_MAX_MS) ? `COFG_REL_MAX_MS
                                                          : hwdata[COFG_MS_W-1:0];
        rec = '0;

        unique case (st_r.fsm)
            ST_NORMAL: begin
                if (start) begin
                    st_nxt.fsm = ST_INIT;
                end
            end
            ST_INIT: begin
                st_nxt.remain = rel_cur;
                st_nxt.elapsed = '0;
                if (rel_cur == '0) begin
                    st_nxt.fsm = ST_NORMAL;
                end else begin
                    st_nxt.fsm = fault_any ? ST_TRIP : ST_ACTIVE;
                end
            end
            ST_ACTIVE, ST_TRIP: begin
                if (start) begin
                    st_nxt.remain = rel_cur;
                    st_nxt.elapsed = '0;
                    st_nxt.fsm = (rel_cur == '0) ? ST_NORMAL : (fault_any ? ST_TRIP : ST_ACTIVE);
                end else if (tick_win && st_r.remain == COFG_MS_W'(1)) begin
                    st_nxt.remain = '0;
                    st_nxt.fsm = ST_NORMAL;
                end else begin
                    if (tick_win) begin
                        st_nxt.remain = st_r.remain - COFG_MS_W'(1);
                        st_nxt.elapsed = st_r.elapsed + COFG_MS_W'(1);
                    end
                    st_nxt.fsm = fault_any ? ST_TRIP : ST_ACTIVE;
                end
            end
        endcase

        cur_flags = {st_r.fsm == ST_TRIP, win, block_s, st_r.fsm == ST_INIT};
        if (st_r.force_en && st_r.force_sel != FORCE_NONE) begin
            cur_flags = {st_r.force_sel == FORCE_TRIP, st_r.force_sel == FORCE_ACTIVE,
                         st_r.force_sel == FORCE_BLOCKED, 1'b0};
        end
        st_nxt.ind.flags = cur_flags;
        if (cur_flags[3]) begin
            st_nxt.ind.cond = COND_TRIP;
        end else if (cur_flags[2]) begin
            st_nxt.ind.cond = COND_ACTIVE;
        end else if (cur_flags[0]) begin
            st_nxt.ind.cond = COND_INIT;
        end else if (cur_flags[1]) begin
            st_nxt.ind.cond = COND_BLOCKED;
        end else begin
            st_nxt.ind.cond = COND_NORMAL;
        end

        st_nxt.prev_flags = st_r.ind.flags;
        for (int k = 0; k < 4; k++) begin
            ev[2*k] = st_r.ind.flags[k] & ~st_r.prev_flags[k];
            ev[2*k+1] = ~st_r.ind.flags[k] & st_r.prev_flags[k];
        end
        ev_store = ev & st_r.evt_mask;

        rec.stamp = st_r.stamp;
        rec.sg = st_r.sg;
        rec.remain = st_r.remain;
        rec.elapsed = st_r.elapsed;
        // Only the lowest stored event of a cycle reaches the event port; all reach the IRQ bits.
        for (int k = 7; k >= 0; k--) begin
            if (ev_store[k]) begin
                rec.id = cofg_evt_t'(3'(k));
            end
        end
        if (ev_store != 8'h00) begin
            st_nxt.evt_stb = 1'b1;
            st_nxt.last_evt = rec;
        end

        if (ev[EVT_ACTIVE_ON]) begin
            rec.id = EVT_ACTIVE_ON;
            st_nxt.log[st_r.log_wr] = rec;
            st_nxt.log_wr = (st_r.log_wr == 4'(COFG_LOG_DEPTH - 1)) ? 4'h0
                                                                    : st_r.log_wr + 4'h1;
            if (st_r.log_cnt != 4'(COFG_LOG_DEPTH)) begin
                st_nxt.log_cnt = st_r.log_cnt + 4'h1;
            end
        end

        if (tick_free) begin
            st_nxt.stamp = st_r.stamp + 32'h00000001;
        end

        // Bus data phase. Reads take one wait state so hrdata comes from a flop.
        if (st_r.ap.valid && st_r.ap.write) begin
            st_nxt.ap.valid = 1'b0;
            case (st_r.ap.addr)
                `COFG_OFF_CTRL: begin
                    st_nxt.force_sel = cofg_force_t'(hwdata[`COFG_CTRL_FORCE_LSB +: 2]);
                    st_nxt.force_en = hwdata[`COFG_CTRL_FEN_BIT];
                    st_nxt.sg = hwdata[`COFG_CTRL_SG_LSB +: 3];
                end
                `COFG_OFF_IRQ_STS: st_nxt.irq_sts = st_r.irq_sts & ~hwdata[7:0];
                `COFG_OFF_IRQ_MASK: st_nxt.irq_mask = hwdata[7:0];
                `COFG_OFF_EVT_MASK: st_nxt.evt_mask = hwdata[7:0];
                `COFG_OFF_TSTAMP: st_nxt.stamp = hwdata;
                `COFG_OFF_LOG_SEL: begin
                    if (hwdata[3:0] < 4'(COFG_LOG_DEPTH)) begin
                        st_nxt.log_sel = hwdata[3:0];
                    end
                end
                default: begin
                    if (st_r.ap.addr >= `COFG_OFF_REL_BASE && st_r.ap.addr < `COFG_OFF_REL_END) begin
                        st_nxt.rel[st_r.ap.addr[4:2]] = wval;
                    end
                end
            endcase
        end else if (st_r.ap.valid) begin
            st_nxt.ap.valid = 1'b0;
            st_nxt.hready = 1'b1;
            st_nxt.hrdata = rd_val;
        end
        if (hsel && htrans[1] && hready) begin
            st_nxt.ap.valid = 1'b1;
            st_nxt.ap.write = hwrite;
            st_nxt.ap.addr = haddr[7:0];
            st_nxt.hready = hwrite;
        end

        // Event set wins over a same-cycle clear.
        st_nxt.irq_sts = st_nxt.irq_sts | ev;
        st_nxt.irq = |(st_r.irq_sts & st_r.irq_mask);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.fsm <= ST_NORMAL;
            st_r.evt_mask <= `COFG_EVT_MASK_RST;
            st_r.hready <= 1'b1;
            for (int g = 0; g < COFG_NUM_SG; g++) begin
                st_r.rel[g] <= `COFG_REL_RST_MS;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hreadyout = st_r.hready;
    assign hrdata = st_r.hrdata;
    assign hresp = 1'b0;
    assign trip = st_r.ind.flags[3];
    assign active = st_r.ind.flags[2];
    assign blocked = st_r.ind.flags[1];
    assign cond_code = st_r.ind.cond;
    assign irq = st_r.irq;
    assign evt_stb = st_r.evt_stb;
    assign evt_id = st_r.last_evt.id;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_init;
        st_r.fsm == ST_INIT;
    endsequence
    sequence s_open;
        win;
    endsequence

    arm_start_a: assert property (
        (st_r.fsm == ST_NORMAL && start && rel_cur != '0) |=> s_init ##1 s_open
    ) else $error("arm edge did not open the window");
    win_hold_a: assert property (
        (win && st_r.remain > COFG_MS_W'(1) && !arm_edge) |=> win
    ) else $error("window closed before interval ended");
    win_end_a: assert property (
        (win && tick_win && st_r.remain == COFG_MS_W'(1) && !arm_edge) |=> st_r.fsm == ST_NORMAL
    ) else $error("window outlived its interval");
    trip_fast_a: assert property (
        (win && fault_any && !arm_edge && !(tick_win && st_r.remain == COFG_MS_W'(1)))
        |=> st_r.fsm == ST_TRIP ##1 trip || st_r.force_en
    ) else $error("fault in window did not trip");
    trip_cause_a: assert property (
        (st_r.fsm == ST_TRIP) |-> $past(fault_any)
    ) else $error("trip without fault start");
    block_start_a: assert property (
        (st_r.fsm == ST_NORMAL && block_s) |=> st_r.fsm == ST_NORMAL
    ) else $error("window started while blocked");
    outs_a: assert property (
        !st_r.force_en |=> (trip == $past(st_r.fsm == ST_TRIP)) && (active == $past(win))
    ) else $error("outputs do not follow window state");
    force_a: assert property (
        (st_r.force_en && st_r.force_sel == FORCE_TRIP) |=> trip && !active && !blocked
    ) else $error("forced trip not applied");
    cond_a: assert property (
        (trip |-> cond_code == COND_TRIP) and (blocked && !trip && !active && $past(!win)
        && $past(st_r.fsm != ST_INIT) |-> cond_code == COND_BLOCKED)
    ) else $error("condition code wrong");
    evt_a: assert property (
        $rose(trip) |=> st_r.irq_sts[EVT_TRIP_ON] ##1 (irq || !st_r.irq_mask[EVT_TRIP_ON])
    ) else $error("trip ON event missing");
    stamp_a: assert property (
        evt_stb |-> st_r.last_evt.stamp == $past(st_r.stamp)
    ) else $error("event stamp not captured");
    log_a: assert property (
        $rose(active) |=> st_r.log_wr != $past(st_r.log_wr)
    ) else $error("activation not logged");
    sg_a: assert property (
        s_init |=> st_r.remain == $past(rel_cur)
    ) else $error("interval not from active group");
    zero_a: assert property (
        (s_init and (rel_cur == '0)) |=> st_r.fsm == ST_NORMAL
    ) else $error("zero interval opened a window");
    restart_a: assert property (
        (win && start) |=> st_r.remain == $past(rel_cur) && st_r.elapsed == '0
    ) else $error("arm edge did not restart interval");
endmodule
`default_nettype wire

// ### tb/cofg_partner.sv
`timescale 1ns/1ps
`default_nettype none
module cofg_partner (
    input wire logic clk, // System clock.
    output logic arm, // Breaker close command.
    output logic block, // Block request.
    output logic [3:0] fault_start // Protection starts.
);
    initial begin
        arm = 1'b0;
        block = 1'b0;
        fault_start = 4'h0;
    end
    // Arm rises for three clocks, like a close command.
    task automatic close_cmd();
        @(posedge clk);
        arm <= 1'b1;
        repeat (3) @(posedge clk);
        arm <= 1'b0;
    endtask
    task automatic set_lines(input logic b, input logic [3:0] f);
        @(posedge clk);
        block <= b;
        fault_start <= f;
    endtask
endmodule
`default_nettype wire

// ### tb/cofg_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "cofg_params.svh"
module cofg_top_test;
    import cofg_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] q;
    wire logic hreadyout, hresp, arm, block, blocked, active, trip, irq, evt_stb;
    wire logic [31:0] hrdata;
    wire logic [2:0] cond_code, evt_id;
    wire logic [3:0] fault_start;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    cofg_top #(.TICK_CYCLES(4), .NUM_FAULT(4)) i_cofg_top (.clk(clk), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .arm(arm), .block(block), .fault_start(fault_start),
        .blocked(blocked), .active(active), .trip(trip), .cond_code(cond_code),
        .irq(irq), .evt_stb(evt_stb), .evt_id(evt_id));
    cofg_partner i_cofg_partner (.clk(clk), .arm(arm), .block(block),
        .fault_start(fault_start));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // The run is far shorter than this ceiling; reaching it means a hung wait.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic outs(input logic [2:0] bat, input logic [2:0] c);
        chk({29'h0, blocked, active, trip}, {29'h0, bat});
        chk({29'h0, cond_code}, {29'h0, c});
    endtask
    task automatic t_reset();
        outs(3'h0, 3'h0);
        chk({31'h0, hresp}, 32'h0);
        bus(1'b0, `COFG_OFF_REL_BASE, 32'h0);
        chk(q, {11'h0, `COFG_REL_RST_MS});
        bus(1'b0, 8'hFC, 32'h0);
        chk(q, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_window();
        bus(1'b1, `COFG_OFF_REL_BASE, 32'h14);
        bus(1'b1, `COFG_OFF_IRQ_MASK, 32'h10);
        i_cofg_partner.close_cmd();
        // The interrupt line trails the active indication by two clocks.
        repeat (5) @(posedge clk);
        outs(3'h2, 3'h2);
        chk({31'h0, irq}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            i_cofg_partner.set_lines(1'b0, 4'h1 << i);
            repeat (5) @(posedge clk);
            outs(3'h3, 3'h3);
            i_cofg_partner.set_lines(1'b0, 4'h0);
            repeat (2) @(posedge clk);
        end
        repeat (100) @(posedge clk);
        outs(3'h0, 3'h0);
        bus(1'b0, `COFG_OFF_LOG_COUNT, 32'h0);
        chk(q, 32'h1);
        bus(1'b0, `COFG_OFF_LOG_INFO, 32'h0);
        chk(q, {29'h0, EVT_ACTIVE_ON});
        bus(1'b0, `COFG_OFF_LOG_REMAIN, 32'h0);
        chk(q, 32'h14);
        bus(1'b1, `COFG_OFF_IRQ_STS, 32'hFF);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("test window done");
    endtask
    task automatic t_restart();
        i_cofg_partner.close_cmd();
        repeat (50) @(posedge clk);
        i_cofg_partner.close_cmd();
        repeat (50) @(posedge clk);
        chk({31'h0, active}, 32'h1);
        repeat (100) @(posedge clk);
        chk({31'h0, active}, 32'h0);
        $display("test restart done");
    endtask
    task automatic t_block();
        i_cofg_partner.set_lines(1'b1, 4'h0);
        repeat (4) @(posedge clk);
        outs(3'h4, 3'h4);
        @(posedge clk);
        chk({31'h0, evt_stb}, 32'h1);
        chk({29'h0, evt_id}, {29'h0, EVT_BLOCK_ON});
        i_cofg_partner.close_cmd();
        repeat (8) @(posedge clk);
        i_cofg_partner.set_lines(1'b1, 4'hF);
        repeat (5) @(posedge clk);
        outs(3'h4, 3'h4);
        i_cofg_partner.set_lines(1'b0, 4'h0);
        repeat (4) @(posedge clk);
        $display("test block done");
    endtask
    task automatic t_group();
        bus(1'b1, `COFG_OFF_CTRL, 32'h10);
        bus(1'b1, `COFG_OFF_REL_BASE + 8'h04, 32'h0);
        i_cofg_partner.close_cmd();
        repeat (2) @(posedge clk);
        chk({29'h0, cond_code}, {29'h0, COND_INIT});
        repeat (6) @(posedge clk);
        chk({31'h0, active}, 32'h0);
        bus(1'b1, `COFG_OFF_CTRL, 32'h0);
        i_cofg_partner.close_cmd();
        repeat (4) @(posedge clk);
        chk({31'h0, active}, 32'h1);
        repeat (100) @(posedge clk);
        $display("test group done");
    endtask
    task automatic t_force();
        for (int f = 1; f < 4; f++) begin
            bus(1'b1, `COFG_OFF_CTRL, 32'(f));
            repeat (3) @(posedge clk);
            chk({29'h0, blocked, active, trip}, 32'h0);
            bus(1'b1, `COFG_OFF_CTRL, 32'(f) | 32'h4);
            repeat (3) @(posedge clk);
            chk({29'h0, blocked, active, trip}, 32'h4 >> (f - 1));
        end
        bus(1'b1, `COFG_OFF_CTRL, 32'h0);
        $display("test force done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_window();
        t_restart();
        t_block();
        t_group();
        t_force();
        complete_run();
    end
endmodule
`default_nettype wire
